/* design/cmc_regs.svh */
// register offsets and field positions of the mailbox control storage
// assumes a byte-wide register port, one register per address
`ifndef CMC_REGS_SVH
`define CMC_REGS_SVH
// byte slot inside a set: address = set * 8 + slot
`define CMC_SLOT_LENGTH 3'h0
`define CMC_SLOT_SPARE_A 3'h1
`define CMC_SLOT_SPARE_B 3'h2
`define CMC_SLOT_SPARE_C 3'h3
`define CMC_SLOT_TYPE_ID 3'h4
`define CMC_SLOT_BASE_HI 3'h5
`define CMC_SLOT_EXT_LO 3'h6
`define CMC_SLOT_EXT_MID 3'h7
// first address above the storage
`define CMC_ADDR_LIMIT 8'h80
// read value of an unmapped address
`define CMC_RD_UNMAPPED 8'h00
// fields
`define CMC_LEN_FIELD 3:0
`define CMC_LEN_LONG_BIT 3
`define CMC_LEN_SHORT_FIELD 2:0
`define CMC_LEN_MAX 4'h8
`define CMC_BASE_LO_FIELD 7:5
`define CMC_REMOTE_BIT 4
`define CMC_EXT_FMT_BIT 3
`define CMC_EXT_HI_FIELD 1:0
// reserved bit of the type byte and upper reserved nibble of the length byte
`define CMC_RESV_BIT 2
`define CMC_RESV_HI_FIELD 7:4
// slot part of a register index
`define CMC_SLOT_FIELD 2:0
// halves of the assembled base identifier
`define CMC_BASE_OUT_LO 2:0
`define CMC_BASE_OUT_HI 10:3
// reset values of the outputs
`define CMC_RST_BYTE 8'h00
`define CMC_RST_LEN 4'h0
`define CMC_RST_BASE 11'h000
`define CMC_RST_EXT 18'h00000
`endif

/* design/cmc_pkg.sv */
// types shared by the mailbox control storage
// assumes the register header is included beside it
package cmc_pkg;
  typedef logic [7:0] cmc_byte_t;
  typedef logic [10:0] cmc_base_id_t;
  typedef logic [17:0] cmc_ext_id_t;
  typedef logic [3:0] cmc_len_t;
endpackage

/* design/cmc_mailbox_ctrl.sv */
// mailbox control storage: sixteen sets of eight byte registers,
// a transmit field lookup and the mailbox 0 receive identifier match
// assumes one clock, a byte register port with strobes and masks
// supplied by the acceptance mask registers outside this block
//
// Overview of operation
// R1: sixteen sets of eight read/write byte registers
// R2: software initialises all bytes; no reset value
// R3: length code above seven means eight bytes
// R4: reserved bits are plain storage, no function
// R5: base identifier split over bytes six and five
// R6: byte five bit four selects remote frame
// R7: byte five bit three selects extended format
// R8: extension identifier split over bytes five, eight, seven
// R9: mailbox 0 match skips bits whose mask is one
// R10: standard format ignores extension identifier bits
`include "cmc_regs.svh"

module cmc_mailbox_ctrl
  import cmc_pkg::*;
#(
  parameter int MB_COUNT = 16,
  parameter int MB_BYTES = 8
)
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic wr_stb_in,
  input wire logic rd_stb_in,
  output logic [7:0] rd_data_out,
  input wire logic [3:0] tx_sel_in,
  output logic [3:0] tx_length_out,
  output logic tx_remote_out,
  output logic tx_extended_out,
  output logic [10:0] tx_base_id_out,
  output logic [17:0] tx_ext_id_out,
  input wire logic rx_check_in,
  input wire logic rx_extended_in,
  input wire logic [10:0] rx_base_id_in,
  input wire logic [17:0] rx_ext_id_in,
  input wire logic [10:0] acceptance_mask_base_in,
  input wire logic [17:0] acceptance_mask_ext_in,
  output logic rx_accept_out,
  output logic rx_done_out
);

  localparam int ENTRIES = MB_COUNT * MB_BYTES;
  localparam int IDX_W = $clog2(ENTRIES);

  // byte storage, flops without reset
  cmc_byte_t store_r [ENTRIES];
  logic addr_hit;
  logic [IDX_W-1:0] idx;
  logic [IDX_W-1:0] sel_base;

  // address decode
  always_comb
  begin
    if (addr_in < `CMC_ADDR_LIMIT)
    begin
      addr_hit = 1'b1;
    end
    else
    begin
      addr_hit = 1'b0;
    end
  end

  assign idx = addr_in[IDX_W-1:0];

  // one write port per entry; contents stay undefined until written
  genvar g;
  generate
    for (g = 0; g < ENTRIES; g++)
    begin : g_entry
      always_ff @(posedge ref_clk_in)
      begin
        if (wr_stb_in && addr_hit && (idx == IDX_W'(g))) // R1
        begin
          store_r[g] <= wr_data_in; // R2 R4
        end
      end
    end
  endgenerate

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rd_data_out <= `CMC_RST_BYTE;
    end
    else if (rd_stb_in && addr_hit)
    begin
      rd_data_out <= store_r[idx]; // R1 R4
    end
    else
    begin
      rd_data_out <= `CMC_RD_UNMAPPED;
    end
  end

  // bytes of the set chosen by the transmit engine
  cmc_byte_t sel_len;
  cmc_byte_t sel_type;
  cmc_byte_t sel_bhi;
  cmc_byte_t sel_elo;
  cmc_byte_t sel_emid;

  assign sel_base = {tx_sel_in, `CMC_SLOT_LENGTH};
  assign sel_len = store_r[sel_base];
  assign sel_type = store_r[{tx_sel_in, `CMC_SLOT_TYPE_ID}];
  assign sel_bhi = store_r[{tx_sel_in, `CMC_SLOT_BASE_HI}];
  assign sel_elo = store_r[{tx_sel_in, `CMC_SLOT_EXT_LO}];
  assign sel_emid = store_r[{tx_sel_in, `CMC_SLOT_EXT_MID}];

  // decoded frame length in bytes
  cmc_len_t len_nxt;
  always_comb
  begin
    if (sel_len[`CMC_LEN_LONG_BIT]) // R3
    begin
      len_nxt = `CMC_LEN_MAX;
    end
    else
    begin
      len_nxt = {1'b0, sel_len[`CMC_LEN_SHORT_FIELD]};
    end
  end

  // transmit fields, refreshed every cycle from the selected set
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tx_length_out <= `CMC_RST_LEN;
      tx_remote_out <= 1'b0;
      tx_extended_out <= 1'b0;
      tx_base_id_out <= `CMC_RST_BASE;
      tx_ext_id_out <= `CMC_RST_EXT;
    end
    else
    begin
      tx_length_out <= len_nxt; // R3
      tx_remote_out <= sel_type[`CMC_REMOTE_BIT]; // R6
      tx_extended_out <= sel_type[`CMC_EXT_FMT_BIT]; // R7
      tx_base_id_out <= {sel_bhi, sel_type[`CMC_BASE_LO_FIELD]}; // R5
      if (sel_type[`CMC_EXT_FMT_BIT])
      begin
        tx_ext_id_out <= {sel_type[`CMC_EXT_HI_FIELD], sel_emid, sel_elo}; // R8
      end
      else
      begin
        tx_ext_id_out <= `CMC_RST_EXT; // R10
      end
    end
  end

  // stored identifier of mailbox 0, the set used for the receive match
  cmc_base_id_t mb0_base;
  cmc_ext_id_t mb0_ext;
  logic mb0_extended;
  logic base_ok;
  logic ext_ok;
  logic accept_nxt;

  assign mb0_base = {store_r[`CMC_SLOT_BASE_HI], store_r[`CMC_SLOT_TYPE_ID][`CMC_BASE_LO_FIELD]};
  assign mb0_ext = {store_r[`CMC_SLOT_TYPE_ID][`CMC_EXT_HI_FIELD],
                    store_r[`CMC_SLOT_EXT_MID], store_r[`CMC_SLOT_EXT_LO]};
  assign mb0_extended = store_r[`CMC_SLOT_TYPE_ID][`CMC_EXT_FMT_BIT];

  // masked compare: a mask bit of one drops that bit from the test
  assign base_ok = (((rx_base_id_in ^ mb0_base) & ~acceptance_mask_base_in) == '0); // R9
  assign ext_ok = (((rx_ext_id_in ^ mb0_ext) & ~acceptance_mask_ext_in) == '0); // R9
  assign accept_nxt = base_ok && (rx_extended_in == mb0_extended)
                      && (!mb0_extended || ext_ok); // R10

  // match verdict held until the next check; done is a pulse
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rx_accept_out <= 1'b0;
      rx_done_out <= 1'b0;
    end
    else
    begin
      rx_done_out <= rx_check_in;
      if (rx_check_in)
      begin
        rx_accept_out <= accept_nxt; // R9
      end
    end
  end

  // checks
  sequence s_write;
    wr_stb_in && addr_hit;
  endsequence

  sequence s_read_same;
    rd_stb_in && (addr_in == $past(addr_in));
  endsequence

  sequence s_check;
    rx_check_in;
  endsequence

  sequence s_spare_write;
    wr_stb_in && addr_hit && (idx[`CMC_SLOT_FIELD] == `CMC_SLOT_SPARE_A);
  endsequence

  AST_READ_BACK: assert property ( // R1
    @(posedge ref_clk_in) disable iff (rst_in)
    s_write ##1 s_read_same |=> (rd_data_out == $past(wr_data_in, 2)))
    else $error("read data differs from the byte just written");

  AST_RESERVED_KEEP: assert property ( // R4
    @(posedge ref_clk_in) disable iff (rst_in)
    (wr_stb_in && addr_hit && (idx[`CMC_SLOT_FIELD] == `CMC_SLOT_LENGTH)) ##1 s_read_same
    |=> (rd_data_out[`CMC_RESV_HI_FIELD] == $past(wr_data_in[`CMC_RESV_HI_FIELD], 2)))
    else $error("reserved bits of the length byte not kept");

  AST_UNMAPPED_ZERO: assert property ( // R1
    @(posedge ref_clk_in) disable iff (rst_in)
    (rd_stb_in && !addr_hit) |=> (rd_data_out == `CMC_RD_UNMAPPED))
    else $error("unmapped read not zero");

  AST_LEN_CAP: assert property ( // R3
    @(posedge ref_clk_in) disable iff (rst_in)
    sel_len[`CMC_LEN_LONG_BIT] |=> (tx_length_out == `CMC_LEN_MAX))
    else $error("long length code not capped at eight");

  AST_LEN_SHORT: assert property ( // R3
    @(posedge ref_clk_in) disable iff (rst_in)
    !sel_len[`CMC_LEN_LONG_BIT]
    |=> (tx_length_out == {1'b0, $past(sel_len[`CMC_LEN_SHORT_FIELD])}))
    else $error("short length code not passed through");

  AST_BASE_ID: assert property ( // R5
    @(posedge ref_clk_in) disable iff (rst_in)
    1'b1 |=> (tx_base_id_out[`CMC_BASE_OUT_LO] == $past(sel_type[`CMC_BASE_LO_FIELD]))
             && (tx_base_id_out[`CMC_BASE_OUT_HI] == $past(sel_bhi)))
    else $error("base identifier assembled wrongly");

  AST_REMOTE: assert property ( // R6
    @(posedge ref_clk_in) disable iff (rst_in)
    $changed(sel_type[`CMC_REMOTE_BIT]) |=> $changed(tx_remote_out))
    else $error("frame type bit not followed");

  AST_FORMAT: assert property ( // R7
    @(posedge ref_clk_in) disable iff (rst_in)
    1'b1 |=> (tx_extended_out == $past(sel_type[`CMC_EXT_FMT_BIT])))
    else $error("format bit not followed");

  AST_EXT_ID: assert property ( // R8
    @(posedge ref_clk_in) disable iff (rst_in)
    sel_type[`CMC_EXT_FMT_BIT]
    |=> (tx_ext_id_out == {$past(sel_type[`CMC_EXT_HI_FIELD]), $past(sel_emid), $past(sel_elo)}))
    else $error("extension identifier assembled wrongly");

  AST_STD_IGNORES_EXT: assert property ( // R10
    @(posedge ref_clk_in) disable iff (rst_in)
    !tx_extended_out |-> (tx_ext_id_out == `CMC_RST_EXT))
    else $error("standard frame shows extension bits");

  AST_MASK_ALL: assert property ( // R9
    @(posedge ref_clk_in) disable iff (rst_in)
    (rx_check_in && (&acceptance_mask_base_in) && (&acceptance_mask_ext_in)
     && (rx_extended_in == mb0_extended)) |=> (rx_accept_out && rx_done_out))
    else $error("fully masked identifier not accepted");

  AST_MISMATCH: assert property ( // R9
    @(posedge ref_clk_in) disable iff (rst_in)
    (rx_check_in && (((rx_base_id_in ^ mb0_base) & ~acceptance_mask_base_in) != '0))
    |=> !rx_accept_out)
    else $error("unmasked base identifier mismatch accepted");

  // done follows every check by one cycle
  AST_DONE_PULSE: assert property ( // R9
    @(posedge ref_clk_in) disable iff (rst_in)
    s_check |=> rx_done_out)
    else $error("done missing after a check");

  // no done without a check
  AST_DONE_QUIET: assert property ( // R9
    @(posedge ref_clk_in) disable iff (rst_in)
    !rx_check_in |=> !rx_done_out)
    else $error("done without a check");

  // verdict held between checks
  AST_ACCEPT_HOLD: assert property ( // R9
    @(posedge ref_clk_in) disable iff (rst_in)
    !rx_check_in |=> $stable(rx_accept_out))
    else $error("verdict changed without a check");

  // format mismatch always rejects
  AST_FMT_REJECT: assert property ( // R10
    @(posedge ref_clk_in) disable iff (rst_in)
    (s_check ##0 (rx_extended_in != mb0_extended)) |=> !rx_accept_out)
    else $error("format mismatch accepted");

  // unmasked extension mismatch rejects an extended frame
  AST_EXT_MISMATCH: assert property ( // R9
    @(posedge ref_clk_in) disable iff (rst_in)
    (rx_check_in && mb0_extended
     && (((rx_ext_id_in ^ mb0_ext) & ~acceptance_mask_ext_in) != '0)) |=> !rx_accept_out)
    else $error("unmasked extension mismatch accepted");

  // standard frame matched on base bits alone
  AST_STD_SKIPS_EXT: assert property ( // R10
    @(posedge ref_clk_in) disable iff (rst_in)
    (rx_check_in && !mb0_extended && !rx_extended_in
     && (((rx_base_id_in ^ mb0_base) & ~acceptance_mask_base_in) == '0)) |=> rx_accept_out)
    else $error("standard frame rejected on extension bits");

  // exact identifier of the right format is taken
  AST_EXACT_MATCH: assert property ( // R9
    @(posedge ref_clk_in) disable iff (rst_in)
    (rx_check_in && (rx_base_id_in == mb0_base) && (rx_ext_id_in == mb0_ext)
     && (rx_extended_in == mb0_extended)) |=> rx_accept_out)
    else $error("exact identifier rejected");

  // read data idle when no read was made
  AST_RD_IDLE: assert property ( // R1
    @(posedge ref_clk_in) disable iff (rst_in)
    !rd_stb_in |=> (rd_data_out == `CMC_RD_UNMAPPED))
    else $error("read data shown without a read");

  // length never beyond eight bytes
  AST_LEN_RANGE: assert property ( // R3
    @(posedge ref_clk_in) disable iff (rst_in)
    1'b1 |=> (tx_length_out <= `CMC_LEN_MAX))
    else $error("length above eight bytes");

  // frame type value follows the selected set
  AST_REMOTE_VALUE: assert property ( // R6
    @(posedge ref_clk_in) disable iff (rst_in)
    1'b1 |=> (tx_remote_out == $past(sel_type[`CMC_REMOTE_BIT])))
    else $error("frame type value wrong");

  // reserved byte kept whole
  AST_RESERVED_BYTE: assert property ( // R4
    @(posedge ref_clk_in) disable iff (rst_in)
    s_spare_write ##1 s_read_same |=> (rd_data_out == $past(wr_data_in, 2)))
    else $error("reserved byte not kept");

  // reserved bit of the type byte kept
  AST_RESERVED_BIT: assert property ( // R4
    @(posedge ref_clk_in) disable iff (rst_in)
    (wr_stb_in && addr_hit && (idx[`CMC_SLOT_FIELD] == `CMC_SLOT_TYPE_ID)) ##1 s_read_same
    |=> (rd_data_out[`CMC_RESV_BIT] == $past(wr_data_in[`CMC_RESV_BIT], 2)))
    else $error("reserved type bit not kept");

endmodule

/* tb/cmc_node_model.sv */
// far-side node: presents a received identifier for one check cycle
// assumes the bench calls send right after it has set the masks
module cmc_node_model
(
  input wire logic ref_clk_in,
  output logic rx_check_out,
  output logic rx_extended_out,
  output logic [10:0] rx_base_id_out,
  output logic [17:0] rx_ext_id_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial rx_check_out = 1'b0;
  initial rx_extended_out = 1'b0;
  initial rx_base_id_out = 11'h000;
  initial rx_ext_id_out = 18'h00000;
  // one frame id; released lines turn inverse so stale ids never match
  task automatic send(input logic f, input logic [10:0] b, input logic [17:0] e);
    @(posedge ref_clk_in);
    rx_check_out <= 1'b1;
    rx_extended_out <= f;
    rx_base_id_out <= b;
    rx_ext_id_out <= e;
    @(posedge ref_clk_in);
    rx_check_out <= 1'b0;
    rx_extended_out <= ~f;
    rx_base_id_out <= ~b;
    rx_ext_id_out <= ~e;
  endtask
endmodule

/* tb/tb_top.sv */
// bench for the mailbox control storage: register port, tx lookup, rx match
// assumes the design files and the node model are compiled first
module tb_top
  import cmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] addr = 8'h00, wdat = 8'h00, rdat;
  logic wr = 1'b0, rd = 1'b0, rem, extf, rchk, rxf, acc, done;
  logic [3:0] sel = 4'h0, len;
  logic [10:0] base, rb, mb = 11'h000;
  logic [17:0] ext, re, me = 18'h00000;
  cmc_byte_t mem[128];
  int num_errors = 0, checked = 0;
  always #2 ref_clk_in = ~ref_clk_in;
  cmc_mailbox_ctrl DUT (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr),
    .wr_data_in(wdat), .wr_stb_in(wr), .rd_stb_in(rd), .rd_data_out(rdat),
    .tx_sel_in(sel), .tx_length_out(len), .tx_remote_out(rem), .tx_extended_out(extf),
    .tx_base_id_out(base), .tx_ext_id_out(ext), .rx_check_in(rchk),
    .rx_extended_in(rxf), .rx_base_id_in(rb), .rx_ext_id_in(re),
    .acceptance_mask_base_in(mb), .acceptance_mask_ext_in(me),
    .rx_accept_out(acc), .rx_done_out(done));
  cmc_node_model node (.ref_clk_in(ref_clk_in), .rx_check_out(rchk),
    .rx_extended_out(rxf), .rx_base_id_out(rb), .rx_ext_id_out(re));
  // compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // one-cycle write, shadow copy kept for mapped bytes
  task automatic wr_b(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge ref_clk_in);
    wr <= 1'b0;
    if (a < 8'h80) mem[a[6:0]] = d;
  endtask
  // one-cycle read, data looked at in the following cycle only
  task automatic rd_b(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_in);
    rd <= 1'b0;
    #1 chk(rdat, e, "read");
  endtask
  function automatic logic [3:0] x_len(input logic [7:0] c);
    return c[3] ? 4'h8 : {1'b0, c[2:0]};
  endfunction
  function automatic logic [17:0] x_ext(input int b);
    return mem[b+4][3] ? {mem[b+4][1:0], mem[b+7], mem[b+6]} : 18'h00000;
  endfunction
  // select a set, compare every field one cycle later
  task automatic tx_chk(input int s);
    @(posedge ref_clk_in);
    sel <= 4'(s);
    @(posedge ref_clk_in);
    #1 chk(len, x_len(mem[s*8]), "length");
    chk(rem, mem[s*8+4][4], "remote");
    chk(extf, mem[s*8+4][3], "format");
    chk(base, {mem[s*8+5], mem[s*8+4][7:5]}, "base id");
    chk(ext, x_ext(s*8), "ext id");
  endtask
  function automatic logic x_acc(input logic f, input logic [10:0] b, input logic [17:0] e);
    logic [10:0] sb;
    sb = {mem[5], mem[4][7:5]};
    return (((b ^ sb) & ~mb) == 11'h000) && (f == mem[4][3]) &&
      (!mem[4][3] || (((e ^ {mem[4][1:0], mem[7], mem[6]}) & ~me) == 18'h00000));
  endfunction
  task automatic stop_test();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // watchdog well beyond the expected run
  initial
  begin
    #100000;
    num_errors++;
    stop_test();
  end
  // main sequence
  initial
  begin
    void'($urandom(33));
    repeat (3) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 128; i++) wr_b(8'(i), 8'($urandom));
    for (int i = 0; i < 128; i++) rd_b(8'(i), mem[i]);
    wr_b(8'h90, 8'hff);
    rd_b(8'h90, 8'h00);
    rd_b(8'h10, mem[16]);
    $display("test registers done");
    for (int s = 0; s < 16; s++) tx_chk(s);
    for (int c = 0; c < 16; c++)
    begin
      wr_b(8'h08, {4'($urandom), 4'(c)});
      tx_chk(1);
    end
    $display("test lookup done");
    for (int p = 0; p < 2; p++)
    begin
      wr_b(8'h04, {mem[4][7:4], p[0], mem[4][2:0]});
      for (int k = 0; k < 40; k++)
      begin
        logic fx, ax;
        logic [10:0] bx;
        logic [17:0] ex;
        @(posedge ref_clk_in);
        mb <= 11'($urandom);
        me <= 18'($urandom);
        @(posedge ref_clk_in);
        fx = mem[4][3] ^ ($urandom % 5 == 0);
        bx = {mem[5], mem[4][7:5]} ^ (11'($urandom) & mb) ^ (k[0] ? 11'h001 << k % 11 : 11'h0);
        ex = {mem[4][1:0], mem[7], mem[6]} ^ 18'($urandom) & (k[1] ? me : 18'h3ffff);
        ax = x_acc(fx, bx, ex);
        node.send(fx, bx, ex);
        #1 chk(done, 1'b1, "done");
        chk(acc, ax, "accept");
      end
    end
    $display("test match done");
    stop_test();
  end
endmodule
